// *** src/acs_pkg.sv ***
package acs_pkg;

   // ---------------------------------------------------------------
   // widths and word layout
   // ---------------------------------------------------------------
   localparam int RAW_W      = 20;                 // signed filter output
   localparam int RES_W      = 18;                 // offset-binary result
   localparam int TAG_W      = 3;
   localparam int WORD_W     = 24;                 // shifted result word
   localparam int FIFO_W     = RES_W + TAG_W;      // aux bits join at read
   localparam int FIFO_DEPTH = 8;
   localparam int SETTLE_BASE_CYC = 64;            // settle with both rate selects at zero

   // ---------------------------------------------------------------
   // serial command byte and bit counts
   // ---------------------------------------------------------------
   localparam int          CMD_READ_BIT = 7;
   localparam int          CMD_SEL_HI   = 6;
   localparam int          CMD_SEL_LO   = 4;
   localparam logic [2:0]  SEL_RESULT   = 3'h3;
   localparam logic [4:0]  CMD_LAST     = 5'h07;   // 8 command bits
   localparam logic [4:0]  DUMP_LAST    = 5'h07;   // 8 ignored data bits
   localparam logic [4:0]  WORD_LAST    = 5'h17;   // 24 result bits
   localparam logic [3:0]  SYNC_IDLE    = 4'h8;    // pin idle levels: sclk high, rest low

   // ---------------------------------------------------------------
   // modes, sequence lengths, tags, transfer-function registers
   // ---------------------------------------------------------------
   localparam logic [1:0]  MODE_NORMAL  = 2'h0;
   localparam logic [1:0]  MODE_OFFCAL  = 2'h1;
   localparam logic [1:0]  MODE_GAINCAL = 2'h2;
   localparam logic [2:0]  PSEUDO_CNT   = 3'h5;
   localparam logic [2:0]  PAIR_INPUT_SEL_CNT     = 3'h3;
   localparam logic [2:0]  CAL_CNT      = 3'h2;
   localparam logic [2:0]  TAG_CAL      = 3'h7;
   localparam logic [2:0]  TAG_AIN5     = 3'h6;
   localparam logic [2:0]  TAG_PAIR_INPUT_SEL     = 3'h4;
   localparam logic [1:0]  TF_1         = 2'h1;
   localparam logic [1:0]  TF_2         = 2'h2;
   localparam logic [1:0]  TF_3         = 2'h3;
   localparam logic [RAW_W:0] OFFSET_BIN = 21'h020000;

   typedef enum logic [3:0] {
      CH_AIN1 = 4'h0, CH_AIN2 = 4'h1, CH_AIN3 = 4'h2, CH_AIN4 = 4'h3,
      CH_AIN5 = 4'h4, CH_P12  = 4'h5, CH_P34  = 4'h6, CH_P56  = 4'h7,
      CH_OFFSET_CAL_PAIR = 4'h8, CH_GAIN_CAL_PAIR = 4'h9
   } acs_chan_t;

   typedef enum logic [1:0] {
      SER_CMD = 2'h0, SER_READ = 2'h1, SER_DUMP = 2'h2
   } acs_ser_t;

endpackage : acs_pkg

// *** src/acs_sequencer.sv ***
`timescale 1ns/1ps
// Operation
// - normal mode maps pair_input_sel and address bits
// - offset-cal converts offset pair, tf by address
// - gain-cal converts gain pair, same tf rule
// - scan order from pair_input_sel and mode bits
// - one result per channel, then advance, wrap
// - wait full settling before ready and advance
// - offset-cal before gain-cal, both tagged calibration
// - active control change drops ready, restarts filter
// - result register read-only, writes ignored
// - result write takes eight bits, then idle
// - word order: result, zero, aux, tag
// - result is offset binary
// - out-of-range inputs clamp, never wrap
// - bit after result LSB is zero
// - aux pins caught on first falling edge
// - tag codes name the source channel
// - non-scan address picks input or pair
// - input five only reachable while scanning
// - calibration pairs only in calibration modes
// - one bit enables sensor-break currents
// - one bit enables both excitation currents

// -----------------------------------------------------------------
// result fifo
// -----------------------------------------------------------------
module acs_fifo #(
   parameter int W = 21,
   parameter int D = 8
) (
   // clock and control
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic         clkEn,
   input  wire logic         flush,
   // fill side
   input  wire logic         inValid,
   output logic              inReady,
   input  wire logic [W-1:0] inData,
   // drain side
   output logic              outValid,
   input  wire logic         outReady,
   output logic      [W-1:0] outData
);
   localparam int AW = $clog2(D);
   logic [W-1:0]  memQ [D];
   logic [AW-1:0] wrQ, wrD, rdQ, rdD;
   logic [AW:0]   cntQ, cntD;
   logic          push, pop;

   // pointer and level update; flush drops everything held
   always_comb begin
      push = inValid && inReady;
      pop  = outValid && outReady;
      wrD  = wrQ;
      rdD  = rdQ;
      cntD = cntQ;
      if (flush) begin
         wrD  = '0;
         rdD  = '0;
         cntD = '0;
      end else begin
         if (push) wrD = (wrQ == AW'(D - 1)) ? '0 : wrQ + 1'b1;
         if (pop)  rdD = (rdQ == AW'(D - 1)) ? '0 : rdQ + 1'b1;
         cntD = cntQ + (AW+1)'(push) - (AW+1)'(pop);
      end
   end

   assign inReady  = (cntQ != (AW+1)'(D));
   assign outValid = (cntQ != '0);
   assign outData  = memQ[rdQ];

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wrQ  <= '0;
         rdQ  <= '0;
         cntQ <= '0;
      end else if (clkEn) begin
         wrQ  <= wrD;
         rdQ  <= rdD;
         cntQ <= cntD;
      end
   end

   // storage carries no reset, only the pointers matter
   always_ff @(posedge clk) begin
      if (clkEn && push && !flush) memQ[wrQ] <= inData;
   end
endmodule : acs_fifo

// -----------------------------------------------------------------
// channel sequencer and result port
// -----------------------------------------------------------------
module acs_sequencer #(
   parameter int SETTLE_BASE = acs_pkg::SETTLE_BASE_CYC
) (
   // clock, reset, enable
   input  wire logic                     clk,
   input  wire logic                     rst_n,
   input  wire logic                     clkEn,
   // channel control bits
   input  wire logic                     opModeHi,
   input  wire logic                     opModeLo,
   input  wire logic                     pairInputSel,
   input  wire logic                     chanAddrHi,
   input  wire logic                     chanAddrLo,
   input  wire logic                     scanEn,
   input  wire logic [1:0]               filterRateSel,
   input  wire logic [1:0]               modulatorRateSel,
   input  wire logic                     breakCurrentCtl,
   input  wire logic                     excitationCurrentCtl,
   // converter side
   input  wire logic [acs_pkg::RAW_W-1:0] filterData,
   output logic      [3:0]               selChan,
   output logic      [1:0]               tfSel,
   output logic                          filterRestart,
   output logic                          sensorBreakCurrentEn,
   output logic                          excitationCurrentEn,
   // serial pins
   input  wire logic                     sclk,
   input  wire logic                     din,
   output logic                          dout,
   input  wire logic                     auxInHi,
   input  wire logic                     auxInLo,
   output logic                          dataReadyN
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   function automatic logic [acs_pkg::RES_W-1:0] clampResult(logic [acs_pkg::RAW_W-1:0] x);
      logic [acs_pkg::RAW_W:0] s;
      s = {x[acs_pkg::RAW_W-1], x} + acs_pkg::OFFSET_BIN;
      if (s[acs_pkg::RAW_W]) clampResult = '0;
      else if (s[acs_pkg::RAW_W-1:acs_pkg::RES_W] != '0) clampResult = '1;
      else clampResult = s[acs_pkg::RES_W-1:0];
   endfunction : clampResult

   function automatic logic [2:0] chanTag(acs_pkg::acs_chan_t c);
      unique case (c)
         acs_pkg::CH_AIN1, acs_pkg::CH_AIN2, acs_pkg::CH_AIN3,
         acs_pkg::CH_AIN4: chanTag = c[2:0];
         acs_pkg::CH_AIN5, acs_pkg::CH_P56: chanTag = acs_pkg::TAG_AIN5;
         acs_pkg::CH_P12:  chanTag = acs_pkg::TAG_PAIR_INPUT_SEL;
         acs_pkg::CH_P34:  chanTag = acs_pkg::TAG_PAIR_INPUT_SEL + 3'h1;
         default:          chanTag = acs_pkg::TAG_CAL;
      endcase
   endfunction : chanTag

   function automatic logic [1:0] chanTf(acs_pkg::acs_chan_t c);
      unique case (c)
         acs_pkg::CH_AIN1, acs_pkg::CH_AIN2, acs_pkg::CH_P12: chanTf = acs_pkg::TF_1;
         acs_pkg::CH_AIN3, acs_pkg::CH_AIN4, acs_pkg::CH_P34: chanTf = acs_pkg::TF_2;
         default: chanTf = acs_pkg::TF_3;
      endcase
   endfunction : chanTf

   // ---------------------------------------------------------------
   // sequencer and conversion timing
   // ---------------------------------------------------------------
   logic [9:0]         cfgNow, cfgQ, cfgD;
   logic [15:0]        cntQ, cntD, settleTgt;
   logic [2:0]         seqQ, seqD, seqLen, base;
   acs_pkg::acs_chan_t chanQ, chanD, seqChan;
   logic [1:0]         tfQ, tfD, mode, addr;
   logic               restartQ, restartD, drdyNQ, drdyND, changed;
   logic               push, fifoInReady, fifoOutValid, pop, pair_input_sel, scan, calMode;
   logic [acs_pkg::FIFO_W-1:0] fifoOut;

   // rate bits count as channel control: a new rate restarts the settle count
   assign cfgNow  = {modulatorRateSel, filterRateSel, scanEn, opModeHi, opModeLo,
                     pairInputSel, chanAddrHi, chanAddrLo};
   assign scan    = cfgQ[5];
   assign mode    = cfgQ[4:3];
   assign pair_input_sel    = cfgQ[2];
   assign addr    = cfgQ[1:0];
   assign calMode = (mode == acs_pkg::MODE_OFFCAL) || (mode == acs_pkg::MODE_GAINCAL);
   // rate scales the wait; faster modulator shortens it
   assign settleTgt = 16'((SETTLE_BASE << filterRateSel) >> modulatorRateSel);

   // next channel, tf register and settle count
   always_comb begin
      changed  = (cfgNow != cfgQ);
      base     = pair_input_sel ? acs_pkg::PAIR_INPUT_SEL_CNT : acs_pkg::PSEUDO_CNT;
      seqLen   = base + (calMode ? acs_pkg::CAL_CNT : 3'h0);
      if (seqQ < base)
         seqChan = pair_input_sel ? acs_pkg::acs_chan_t'(4'(acs_pkg::CH_P12) + {1'b0, seqQ})
                        : acs_pkg::acs_chan_t'({1'b0, seqQ});
      else
         seqChan = (seqQ == base) ? acs_pkg::CH_OFFSET_CAL_PAIR : acs_pkg::CH_GAIN_CAL_PAIR;
      chanD    = chanQ;
      tfD      = tfQ;
      if (scan) begin
         chanD = seqChan;
         tfD   = chanTf(seqChan);
      end else if (mode == acs_pkg::MODE_NORMAL) begin
         if (!pair_input_sel) begin
            chanD = acs_pkg::acs_chan_t'({2'h0, addr});
            tfD   = chanTf(chanD);
         end else if (addr != 2'h3) begin
            chanD = acs_pkg::acs_chan_t'(4'(acs_pkg::CH_P12) + {2'h0, addr});
            tfD   = chanTf(chanD);
         end
      end else if (calMode && !(pair_input_sel && addr == 2'h3)) begin
         chanD = (mode == acs_pkg::MODE_OFFCAL) ? acs_pkg::CH_OFFSET_CAL_PAIR
                                                : acs_pkg::CH_GAIN_CAL_PAIR;
         tfD   = pair_input_sel ? addr + 2'h1 : (addr[1] ? acs_pkg::TF_2 : acs_pkg::TF_1);
      end
      cfgD     = cfgQ;
      cntD     = cntQ;
      seqD     = seqQ;
      push     = 1'b0;
      restartD = 1'b0;
      if (changed) begin
         cfgD     = cfgNow;
         cntD     = '0;
         seqD     = '0;
         restartD = 1'b1;
      end else if (cntQ >= settleTgt - 16'h1) begin
         // a full fifo stalls the sequencer on the finished channel
         if (fifoInReady) begin
            push = 1'b1;
            cntD = '0;
            if (scan) seqD = (seqQ >= seqLen - 3'h1) ? 3'h0 : seqQ + 3'h1;
         end
      end else begin
         cntD = cntQ + 16'h1;
      end
      drdyND = changed || !fifoOutValid;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cfgQ     <= '0;
         cntQ     <= '0;
         seqQ     <= '0;
         chanQ    <= acs_pkg::CH_AIN1;
         tfQ      <= acs_pkg::TF_1;
         restartQ <= 1'b1;
         drdyNQ   <= 1'b1;
         sensorBreakCurrentEn <= 1'b0;
         excitationCurrentEn  <= 1'b0;
      end else if (clkEn) begin
         cfgQ     <= cfgD;
         cntQ     <= cntD;
         seqQ     <= seqD;
         chanQ    <= chanD;
         tfQ      <= tfD;
         restartQ <= restartD;
         drdyNQ   <= drdyND;
         sensorBreakCurrentEn <= breakCurrentCtl;
         excitationCurrentEn  <= excitationCurrentCtl;
      end
   end

   assign selChan       = chanQ;
   assign tfSel         = tfQ;
   assign filterRestart = restartQ;
   assign dataReadyN    = drdyNQ;

   acs_fifo #(.W(acs_pkg::FIFO_W), .D(acs_pkg::FIFO_DEPTH)) uFifo (
      .clk      (clk),
      .rst_n    (rst_n),
      .clkEn    (clkEn),
      .flush    (changed),
      .inValid  (push),
      .inReady  (fifoInReady),
      .inData   ({clampResult(filterData), chanTag(chanQ)}),
      .outValid (fifoOutValid),
      .outReady (pop),
      .outData  (fifoOut)
   );

   // ---------------------------------------------------------------
   // serial port
   // ---------------------------------------------------------------
   logic [3:0]               syncAQ, syncBQ;
   logic                     sclkPrevQ, sclkRise, sclkFall, firstQ, firstD, doutQ, doutD;
   acs_pkg::acs_ser_t        serQ, serD;
   logic [4:0]               bitQ, bitD;
   logic [7:0]               cmdQ, cmdD, cmdByte;
   logic [acs_pkg::WORD_W-1:0] shQ, shD, word;
   logic [acs_pkg::FIFO_W-1:0] resQ, resD;

   // two stages on every pin before any logic sees it
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         // idle levels, so no false sclk edge follows reset
         syncAQ    <= acs_pkg::SYNC_IDLE;
         syncBQ    <= acs_pkg::SYNC_IDLE;
         sclkPrevQ <= 1'b1;
      end else if (clkEn) begin
         syncAQ    <= {sclk, din, auxInHi, auxInLo};
         syncBQ    <= syncAQ;
         sclkPrevQ <= syncBQ[3];
      end
   end

   // in on rising sclk, out on falling sclk
   always_comb begin
      sclkRise = syncBQ[3] && !sclkPrevQ;
      sclkFall = !syncBQ[3] && sclkPrevQ;
      cmdByte  = {cmdQ[6:0], syncBQ[2]};
      word     = {resQ[acs_pkg::FIFO_W-1:acs_pkg::TAG_W], 1'b0,
                  syncBQ[1:0], resQ[acs_pkg::TAG_W-1:0]};
      serD  = serQ;
      bitD  = bitQ;
      cmdD  = cmdQ;
      shD   = shQ;
      resD  = resQ;
      doutD = doutQ;
      firstD = firstQ;
      pop   = 1'b0;
      unique case (serQ)
         acs_pkg::SER_CMD: if (sclkRise) begin
            cmdD = cmdByte;
            bitD = bitQ + 5'h1;
            if (bitQ == acs_pkg::CMD_LAST) begin
               bitD = '0;
               if (cmdByte[acs_pkg::CMD_SEL_HI:acs_pkg::CMD_SEL_LO] == acs_pkg::SEL_RESULT) begin
                  if (cmdByte[acs_pkg::CMD_READ_BIT]) begin
                     serD   = acs_pkg::SER_READ;
                     firstD = 1'b1;
                     pop    = fifoOutValid;
                     if (fifoOutValid) resD = fifoOut;
                  end else begin
                     serD = acs_pkg::SER_DUMP;
                  end
               end
            end
         end
         acs_pkg::SER_READ: begin
            if (sclkFall) begin
               firstD = 1'b0;
               doutD  = firstQ ? word[acs_pkg::WORD_W-1] : shQ[acs_pkg::WORD_W-1];
               shD    = firstQ ? {word[acs_pkg::WORD_W-2:0], 1'b0}
                               : {shQ[acs_pkg::WORD_W-2:0], 1'b0};
            end
            if (sclkRise && !firstQ) begin
               bitD = bitQ + 5'h1;
               if (bitQ == acs_pkg::WORD_LAST) begin
                  bitD = '0;
                  serD = acs_pkg::SER_CMD;
               end
            end
         end
         acs_pkg::SER_DUMP: if (sclkRise) begin
            bitD = bitQ + 5'h1;
            if (bitQ == acs_pkg::DUMP_LAST) begin
               bitD = '0;
               serD = acs_pkg::SER_CMD;
            end
         end
         default: serD = acs_pkg::SER_CMD;
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         serQ   <= acs_pkg::SER_CMD;
         bitQ   <= '0;
         cmdQ   <= '0;
         shQ    <= '0;
         resQ   <= '0;
         doutQ  <= 1'b0;
         firstQ <= 1'b0;
      end else if (clkEn) begin
         serQ   <= serD;
         bitQ   <= bitD;
         cmdQ   <= cmdD;
         shQ    <= shD;
         resQ   <= resD;
         doutQ  <= doutD;
         firstQ <= firstD;
      end
   end

   assign dout = doutQ;

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   a_restart_drop:  assert property (clkEn && changed |=> filterRestart && dataReadyN)
      else $error("control change did not restart and drop ready");
   a_settle_wait:   assert property (clkEn && push |-> cntQ == settleTgt - 16'h1)
      else $error("result pushed before settling");
   a_scan_step:     assert property (clkEn && push && scan && !changed
                                     |=> seqQ != $past(seqQ))
      else $error("scan did not advance after a result");
   a_cal_tag:       assert property (clkEn && push
                                     && chanQ inside {acs_pkg::CH_OFFSET_CAL_PAIR, acs_pkg::CH_GAIN_CAL_PAIR}
                                     |=> uFifo.memQ[$past(uFifo.wrQ)][acs_pkg::TAG_W-1:0]
                                         == acs_pkg::TAG_CAL)
      else $error("calibration result tag wrong");
   a_offcal_order:  assert property (clkEn && push && scan && !changed
                                     && chanQ == acs_pkg::CH_OFFSET_CAL_PAIR
                                     |=> seqQ == $past(seqQ) + 3'h1)
      else $error("gain cal did not follow offset cal");
   a_ain5_scan:     assert property (clkEn && chanD == acs_pkg::CH_AIN5 |-> scan)
      else $error("input five reached outside scan");
   a_cal_mode:      assert property (clkEn && !changed
                                     && chanD == acs_pkg::CH_GAIN_CAL_PAIR |-> calMode)
      else $error("calibration pair outside calibration mode");
   a_clamp_high:    assert property (clkEn && push && !filterData[acs_pkg::RAW_W-1]
                                     && filterData[acs_pkg::RAW_W-2]
                                     |=> uFifo.memQ[$past(uFifo.wrQ)]
                                         [acs_pkg::FIFO_W-1:acs_pkg::TAG_W] == '1)
      else $error("overrange result wrapped");
   a_reserved_zero: assert property (clkEn && serQ == acs_pkg::SER_READ
                                     && sclkFall && firstQ
                                     |=> shQ[acs_pkg::TAG_W + 3] == 1'b0)
      else $error("reserved bit not zero");
   a_dump_idle:     assert property (clkEn && serQ == acs_pkg::SER_DUMP && sclkRise
                                     && bitQ == acs_pkg::DUMP_LAST |=> serQ == acs_pkg::SER_CMD)
      else $error("write to result did not return to idle");
   a_result_ro:     assert property (clkEn && resD != resQ |-> pop)
      else $error("result changed without a read");

   c_scan_push:  cover property (push && scan);
   c_cal_push:   cover property (push && chanQ == acs_pkg::CH_GAIN_CAL_PAIR);
   c_read_done:  cover property (serQ == acs_pkg::SER_READ ##1 serQ == acs_pkg::SER_CMD);
   c_write_dump: cover property (serQ == acs_pkg::SER_DUMP ##1 serQ == acs_pkg::SER_CMD);
endmodule : acs_sequencer

// *** verification/acs_host_model.sv ***
`timescale 1ns/1ps
// -----------------------------------------------------------------
// serial host: bit-banged three-wire master, 160 ns sclk
// -----------------------------------------------------------------
module acs_host_model (
   // serial pins
   output logic      sclk,
   output logic      din,
   input  wire logic dout
);
   localparam logic [7:0] READ_CMD  = 8'hb0;   // read, select result
   localparam logic [7:0] WRITE_CMD = 8'h30;   // write, select result

   // sclk idles high and stands still between frames
   initial begin
      sclk = 1'h1;
      din  = 1'h1;
   end

   // one period: fall and drive, sample late in low phase, rise
   task automatic xfer(input logic bi, output logic bo);
      sclk = 1'h0;
      din  = bi;
      #80;
      bo   = dout;
      sclk = 1'h1;
      #80;
   endtask : xfer

   // command byte then 24 result bits, msb first
   task automatic readWord(output logic [23:0] w);
      logic b;
      for (int i = 7; i >= 0; i--) xfer(READ_CMD[i], b);
      for (int i = 23; i >= 0; i--) begin
         xfer(i[0], b);   // device ignores din here, keep it moving
         w[i] = b;
      end
   endtask : readWord

   // write to the result register: always eight data bits
   task automatic writeResult(input logic [7:0] d);
      logic b;
      for (int i = 7; i >= 0; i--) xfer(WRITE_CMD[i], b);
      for (int i = 7; i >= 0; i--) xfer(d[i], b);
   endtask : writeResult
endmodule : acs_host_model

// *** verification/acs_tb.sv ***
`timescale 1ns/1ps
module tb;
   // -----------------------------------------------------------------
   // stimulus and observed signals
   // -----------------------------------------------------------------
   logic        clk     = 1'h0;
   logic        rst_n   = 1'h0;
   logic [4:0]  ctl     = 5'h00;   // mode hi/lo, pair select, address hi/lo
   logic        scanEn  = 1'h0;
   logic [1:0]  frs     = 2'h0;
   logic [1:0]  mrs     = 2'h0;
   logic [1:0]  cur     = 2'h0;
   logic [1:0]  aux     = 2'h0;
   logic [19:0] rawBase = 20'h00100;
   logic [3:0]  selChan;
   logic [1:0]  tfSel;
   logic        filterRestart, brk, exc, sclk, din, dout, dataReadyN;
   logic [23:0] w;
   int          fails = 0;
   int          samples_checked = 0;
   // rows: {3'h0, ctl}, channel, {2'h0, tf}; no reserved pair_input_sel address three
   localparam logic [15:0] ROWS [21] = '{16'h0001, 16'h0111, 16'h0222, 16'h0332,
      16'h0451, 16'h0562, 16'h0673, 16'h0881, 16'h0981, 16'h0a82, 16'h0b82,
      16'h0c81, 16'h0d82, 16'h0e83, 16'h1091, 16'h1191, 16'h1292, 16'h1392,
      16'h1491, 16'h1592, 16'h1693};

   // free-running 100 MHz clock
   always #5 clk = ~clk;

   // small settle base keeps each conversion short
   acs_sequencer #(.SETTLE_BASE(8)) dut_u (.clk(clk), .rst_n(rst_n), .clkEn(1'h1),
      .opModeHi(ctl[4]), .opModeLo(ctl[3]), .pairInputSel(ctl[2]),
      .chanAddrHi(ctl[1]), .chanAddrLo(ctl[0]), .scanEn(scanEn),
      .filterRateSel(frs), .modulatorRateSel(mrs),
      .breakCurrentCtl(cur[1]), .excitationCurrentCtl(cur[0]),
      .filterData(rawBase + {16'h0000, selChan}), .selChan(selChan), .tfSel(tfSel),
      .filterRestart(filterRestart), .sensorBreakCurrentEn(brk),
      .excitationCurrentEn(exc), .sclk(sclk), .din(din), .dout(dout),
      .auxInHi(aux[1]), .auxInLo(aux[0]), .dataReadyN(dataReadyN));
   acs_host_model host_u (.sclk(sclk), .din(din), .dout(dout));

   // -----------------------------------------------------------------
   // helpers
   // -----------------------------------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fails++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   task automatic test_done;
      if (fails == 0 && samples_checked > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : test_done

   // inputs always move 1 ns after the rising edge
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : cyc

   // bounded wait for a pending result; running out ends the run
   task automatic waitReady(input int lim);
      int i;
      for (i = 0; i < lim && dataReadyN !== 1'h0; i++) cyc(1);
      if (i == lim) begin
         fails++;
         test_done();
      end
   endtask : waitReady

   // expected offset-binary code, saturating instead of wrapping
   function automatic logic [17:0] res18(input logic [3:0] ch);
      int v;
      v = $signed(rawBase + {16'h0000, ch}) + 131072;
      return (v < 0) ? 18'h00000 : (v > 262143) ? 18'h3ffff : v[17:0];
   endfunction : res18

   task automatic readChk(input logic [3:0] ch, input logic [2:0] tag);
      host_u.readWord(w);
      check(w, {res18(ch), 1'h0, aux, tag});
   endtask : readChk

   // -----------------------------------------------------------------
   // main sequence
   // -----------------------------------------------------------------
   initial begin
      cyc(9);
      check({dataReadyN, filterRestart, selChan, tfSel, brk, exc}, 10'h304);
      cyc(1);
      rst_n = 1'h1;
      // non-scan channel and transfer register selection
      foreach (ROWS[i]) begin
         ctl = ROWS[i][12:8];
         cyc(4);
         check({selChan, 2'h0, tfSel}, ROWS[i][7:0]);
      end
      // current source enables, all four combinations
      for (int k = 0; k < 4; k++) begin
         cur = k[1:0];
         cyc(2);
         check({brk, exc}, k);
      end
      // active change restarts; slower filter lengthens the wait
      ctl = 5'h00;
      frs = 2'h3;
      mrs = 2'h1;
      aux = 2'h2;
      cyc(1);
      check({filterRestart, dataReadyN}, 2'h3);
      cyc(20);
      check(dataReadyN, 1'h1);
      waitReady(60);
      readChk(4'h0, 3'h0);
      // pseudo scan with a refused write first
      frs = 2'h0;
      mrs = 2'h0;
      scanEn = 1'h1;
      ctl = 5'h01;
      host_u.writeResult(8'hff);
      for (int k = 0; k < 6; k++) begin
         aux = k[1:0];
         waitReady(400);
         readChk(k[3:0] % 4'h5, (k % 5 < 4) ? k[2:0] % 3'h5 : 3'h6);
      end
      // pair_input_sel scan in offset-cal mode, saturating high
      rawBase = 20'h7fff0;
      ctl = 5'h0c;
      cyc(2);
      for (int k = 0; k < 5; k++) begin
         waitReady(400);
         readChk(4'h5 + k[3:0], (k < 3) ? 3'h4 + k[2:0] : 3'h7);
      end
      // single gain-cal channel, saturating low
      rawBase = 20'h80000;
      scanEn = 1'h0;
      ctl = 5'h10;
      cyc(2);
      waitReady(400);
      readChk(4'h9, 3'h7);
      test_done();
   end
endmodule : tb
